// file: apms_host.sv
/* Host pin driver and analog core stand-in.
 Assumes its task is called at a rising edge of sys_clk. */
`timescale 1ns/10ps
module apms_host (
	// Clock
	input wire logic sys_clk,
	// Start pin and raw code
	output logic convert_start_n,
	output logic [apms_pkg::SAMPLE_W-1:0] raw_code
);
	import apms_pkg::*;
	// Idle pin high, code held
	initial begin
		convert_start_n = 1'b1;
		raw_code = 12'h000;
	end
	task automatic start_pulse(input int low_cyc, input logic [11:0] code);
		raw_code <= code;
		convert_start_n <= 1'b0;
		repeat (low_cyc) @(posedge sys_clk);
		convert_start_n <= 1'b1;
	endtask : start_pulse
endmodule : apms_host

// file: apms_pkg.sv
/*
 Package for the converter power-mode sequencer: power modes, register map,
 field layout and timing counts at the 40 MHz system clock.
 Assumes a 32-bit Avalon-MM slave port with word addressing by byte address.
*/
package apms_pkg;
	// Clock
	localparam int CLK_HZ = 40000000;
	localparam int NS_PER_S = 1000000000;
	localparam int CLK_PERIOD_NS = NS_PER_S / CLK_HZ;

	// Power management modes
	typedef enum logic [1:0] {
		APMS_PM_NORMAL = 2'h0,
		APMS_PM_FULL_AFTER = 2'h1,
		APMS_PM_FULL_ALWAYS = 2'h2,
		APMS_PM_PART_AFTER = 2'h3
	} apms_pmode_type;

	// Timing: wake-up time and power-on timeout / calibration phases
	localparam int WAKE_US = 5;
	localparam int WAKE_CYC = (WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PON_TOTAL_MS = 70;
	localparam int PON_PHASE_MS = PON_TOTAL_MS / 2;
	localparam int PON_PHASE_CYC_DEF = PON_PHASE_MS * (CLK_HZ / 1000);
	localparam int CONV_CYC_DEF = 184;
	localparam int CNT_W = 24;

	// Register map (byte addresses)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_RESULT = 4'h8;
	localparam logic [31:0] UNMAPPED_RD = 32'hDEADBEEF;

	// Control register fields
	localparam int CTRL_PM_LO = 0;
	localparam int CTRL_PM_HI = 1;
	localparam int CTRL_BIPOLAR = 2;
	localparam int CTRL_SWSTART = 3;
	localparam apms_pmode_type PM_RESET = APMS_PM_NORMAL;

	// Status register fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_REF_ON = 1;
	localparam int STAT_CORE_ON = 2;
	localparam int STAT_CAL_DONE = 3;
	localparam int STAT_PON_ARMED = 4;

	// Sample width and code offset
	localparam int SAMPLE_W = 12;
	localparam logic [11:0] MID_CODE = 12'h800;

	// Power state carried to the analog side
	typedef struct packed {
		logic core_on;
		logic ref_on;
	} apms_power_type;

	// Avalon-MM request
	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} apms_avmm_req_type;
endpackage : apms_pkg

// file: apms_seq.sv
/*
 Power-mode and conversion-start sequencer of a 12-bit sampling converter.
 Holds the control register, wakes and powers down the analog core, runs the
 power-on timeout and self-calibration, and formats the result code.
 Assumes an Avalon-MM master on sys_clk, an asynchronous start pin and an
 analog core whose raw offset-binary code is taken when the conversion count ends.
*/
// Functional notes
// - Power bits: 00 normal, 01 full-down after, 10 full-down, 11 partial after.
// - Full power-down switches off every circuit including the reference.
// - Partial power-down keeps only the on-chip reference powered.
// - First start pulse after power-on runs timeout; the next start runs self-calibration.
// - Control write before any start pulse cancels power-on sequence.
// - After full software power-down, ready within 5 us of wake.
// - Full-down-after mode powers down fully when busy falls; partial-after keeps the reference.
// - Falling start edge begins power-up, ready 5 us later.
// - Rising start edge begins conversion; power down again when done.
// - Bipolar range gives twos complement, step full scale over 4096.
// - Unipolar range gives straight binary.
// - Start pulses ignored while busy high; next accepted after busy falls.
`timescale 1ns/10ps
module apms_seq #(
	parameter int PON_PHASE_CYC = apms_pkg::PON_PHASE_CYC_DEF,
	parameter int CONV_CYC = apms_pkg::CONV_CYC_DEF
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Conversion start pin
	input wire logic convert_start_n,
	// Analog core
	input wire logic [apms_pkg::SAMPLE_W-1:0] raw_code,
	output apms_pkg::apms_power_type power_r,
	output logic busy_r,
	output logic sample_r,
	output logic [apms_pkg::SAMPLE_W-1:0] result_r
);
	import apms_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PON_WAIT = 3'h1,
		ST_CAL = 3'h2,
		ST_WAKE = 3'h3,
		ST_CONV = 3'h4,
		ST_DOWN = 3'h5
	} apms_state_type;

	apms_state_type state_r;
	apms_state_type state_nxt;
	apms_pmode_type pmode_r;
	logic bipolar_r;
	logic sw_start_r;
	logic pon_armed_r;
	logic cal_pending_r;
	logic cal_done_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic start_lvl;
	logic start_lvl_d_r;
	logic ack_r;

	// Start pin synchroniser
	apms_sync u_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.pin_in(convert_start_n),
		.level_out(start_lvl)
	);

	// Bus decode
	wire bus_req = (avs_read | avs_write) & ~ack_r;
	// Write lands at the edge where waitrequest is seen low
	wire wr_ctrl = avs_write & ack_r & (avs_address == REG_CTRL);
	wire [31:0] rd_mux = (avs_address == REG_CTRL) ?
		{28'h0, sw_start_r, bipolar_r, pmode_r} :
		(avs_address == REG_STAT) ?
		{27'h0, pon_armed_r, cal_done_r, power_r.core_on, power_r.ref_on, busy_r} :
		(avs_address == REG_RESULT) ? {20'h0, result_r} : UNMAPPED_RD;

	// Pin edges and start sources
	wire fall_edge = start_lvl_d_r & ~start_lvl;
	wire rise_edge = ~start_lvl_d_r & start_lvl;
	wire sw_go = wr_ctrl & avs_writedata[CTRL_SWSTART];
	wire [1:0] wr_pm = avs_writedata[CTRL_PM_HI:CTRL_PM_LO];
	wire full_always = (pmode_r == APMS_PM_FULL_ALWAYS);
	wire down_after = (pmode_r == APMS_PM_FULL_AFTER) | (pmode_r == APMS_PM_PART_AFTER);
	wire cnt_done = (cnt_r == '0);
	// A control write in the same cycle as the first start cancels arming
	wire pon_live = pon_armed_r & ~wr_ctrl;

	// Power per state and mode
	wire core_on_nxt = ~full_always &
		((state_nxt != ST_DOWN) | (state_nxt == ST_WAKE));
	wire ref_on_nxt = ~full_always &
		((state_nxt != ST_DOWN) | (pmode_r == APMS_PM_PART_AFTER));

	// Result format
	// Bipolar twos complement
	wire [SAMPLE_W-1:0] fmt_code = bipolar_r ? (raw_code ^ MID_CODE) : raw_code;

	// Next state
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_done ? cnt_r : cnt_r - 1'b1;
		case (state_r)
			ST_IDLE: begin
				if (pon_live && fall_edge) begin
					state_nxt = ST_PON_WAIT;
					cnt_nxt = CNT_W'(PON_PHASE_CYC);
				end else if (cal_pending_r && (fall_edge || sw_go)) begin
					state_nxt = ST_CAL;
					cnt_nxt = CNT_W'(PON_PHASE_CYC);
				end else if (rise_edge && !full_always) begin
					state_nxt = ST_CONV;
					cnt_nxt = CNT_W'(CONV_CYC);
				end else if (sw_go && !full_always) begin
					state_nxt = ST_CONV;
					cnt_nxt = CNT_W'(CONV_CYC);
				end
			end
			ST_PON_WAIT, ST_CAL: begin
				if (cnt_done) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_DOWN: begin
				if (!down_after) begin
					state_nxt = ST_IDLE;
				end else if (fall_edge || sw_go) begin
					state_nxt = ST_WAKE;
					cnt_nxt = CNT_W'(WAKE_CYC);
				end
			end
			ST_WAKE: begin
				if (cnt_done) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_CONV: begin
				if (cnt_done) begin
					state_nxt = down_after ? ST_DOWN : ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Sequencer and power registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			start_lvl_d_r <= 1'b1;
			power_r <= '{core_on: 1'b1, ref_on: 1'b1};
			busy_r <= 1'b0;
			sample_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			start_lvl_d_r <= start_lvl;
			power_r <= '{core_on: core_on_nxt, ref_on: ref_on_nxt};
			// Busy covers timeout, calibration and conversion
			busy_r <= (state_nxt == ST_PON_WAIT) | (state_nxt == ST_CAL) |
				(state_nxt == ST_CONV);
			sample_r <= (state_r == ST_IDLE) & (state_nxt == ST_CONV);
		end
	end

	// Power-on calibration tracking
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pon_armed_r <= 1'b1;
			cal_pending_r <= 1'b0;
			cal_done_r <= 1'b0;
		end else if (state_r == ST_IDLE && state_nxt == ST_PON_WAIT) begin
			pon_armed_r <= 1'b0;
		end else if (state_r == ST_PON_WAIT && state_nxt == ST_IDLE) begin
			cal_pending_r <= 1'b1;
		end else if (state_r == ST_CAL && state_nxt == ST_IDLE) begin
			cal_pending_r <= 1'b0;
			cal_done_r <= 1'b1;
		end else if (wr_ctrl && pon_armed_r) begin
			pon_armed_r <= 1'b0;
		end
	end

	// Control register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pmode_r <= PM_RESET;
			bipolar_r <= 1'b0;
		end else if (wr_ctrl) begin
			pmode_r <= apms_pmode_type'(wr_pm);
			bipolar_r <= avs_writedata[CTRL_BIPOLAR];
		end
	end

	// Software start flag, cleared when a conversion ends; set wins over clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sw_start_r <= 1'b0;
		end else if (sw_go) begin
			sw_start_r <= 1'b1;
		end else if (busy_r && state_nxt != ST_CONV && state_r == ST_CONV) begin
			sw_start_r <= 1'b0;
		end
	end

	// Result capture at end of conversion
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			result_r <= '0;
		end else if (state_r == ST_CONV && cnt_done) begin
			result_r <= fmt_code;
		end
	end

	// Bus answer: one wait cycle, then ack
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ack_r <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end else begin
			ack_r <= bus_req;
			avs_waitrequest <= ~bus_req; // Low only in the answer cycle
			if (bus_req) begin
				avs_readdata <= rd_mux;
			end
		end
	end

endmodule : apms_seq

// file: apms_seq_bench.sv
/* Self-checking bench for the sequencer, one task per scenario.
 Assumes the host model drives the pin and the raw code. */
`timescale 1ns/10ps
module apms_seq_bench;
	import apms_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	apms_avmm_req_type req = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic convert_start_n;
	logic [SAMPLE_W-1:0] raw_code;
	apms_power_type power_r;
	logic busy_r;
	logic sample_r;
	logic [SAMPLE_W-1:0] result_r;
	logic [31:0] rd_v;
	int errors = 0;
	int n_checks = 0;
	int n_samp = 0;
	apms_seq #(.PON_PHASE_CYC(50), .CONV_CYC(40)) uut (.sys_clk, .srst,
		.avs_address(req.address), .avs_read(req.read), .avs_write(req.write),
		.avs_writedata(req.writedata), .avs_readdata, .avs_waitrequest,
		.convert_start_n, .raw_code, .power_r, .busy_r, .sample_r, .result_r);
	apms_host host (.sys_clk, .convert_start_n, .raw_code);
	// Clock and start counter
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (sample_r === 1'b1)
		n_samp <= n_samp + 1;
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic stop_test;
		if (errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic give_up;
		errors++;
		stop_test();
	endtask : give_up
	task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		req <= '{a, !wr, wr, d};
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (i == 20)
			give_up();
		rd_v = avs_readdata;
		req <= '0;
	endtask : bus
	task automatic wait_idle;
		int i;
		repeat (8) @(posedge sys_clk);
		for (i = 0; i < 3000 && busy_r !== 1'b0; i++)
			@(posedge sys_clk);
		if (i == 3000)
			give_up();
	endtask : wait_idle
	task automatic do_reset;
		srst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
	endtask : do_reset
	task automatic t_cancel;
		bus(REG_CTRL, 1'b0, 32'h0);
		chk("ctrl reset", rd_v, 32'h0);
		bus(REG_STAT, 1'b0, 32'h0);
		chk("stat reset", rd_v, 32'h16);
		bus(4'hC, 1'b0, 32'h0);
		chk("unmapped", rd_v, UNMAPPED_RD);
		bus(REG_CTRL, 1'b1, 32'h0);
		host.start_pulse(5, 12'hABC);
		wait_idle();
		chk("cancel conv", n_samp, 1);
		chk("unipolar", result_r, 12'hABC);
	endtask : t_cancel
	task automatic t_pon;
		int s0;
		s0 = n_samp;
		host.start_pulse(5, 12'h123);
		repeat (20) @(posedge sys_clk);
		chk("timeout busy", busy_r, 1'b1);
		host.start_pulse(5, 12'h123);
		wait_idle();
		host.start_pulse(5, 12'h123);
		wait_idle();
		chk("no conv", n_samp - s0, 0);
		bus(REG_STAT, 1'b0, 32'h0);
		chk("cal done", rd_v[3], 1'b1);
		bus(REG_CTRL, 1'b1, 32'h4);
		host.start_pulse(5, 12'h123);
		wait_idle();
		chk("bipolar", result_r, 12'h923);
	endtask : t_pon
	task automatic t_modes;
		int s0;
		s0 = n_samp;
		bus(REG_CTRL, 1'b1, 32'h3);
		host.start_pulse(5, 12'h0F0);
		wait_idle();
		chk("part down", power_r, 2'h1);
		host.start_pulse(210, 12'h0F0);
		chk("woken", power_r, 2'h3);
		wait_idle();
		chk("rise starts", n_samp - s0, 2);
		bus(REG_CTRL, 1'b1, 32'h1);
		host.start_pulse(210, 12'h0F0);
		wait_idle();
		chk("full down", power_r, 2'h0);
		host.start_pulse(5, 12'h0F0);
		wait_idle();
		chk("short lost", n_samp - s0, 3);
		bus(REG_CTRL, 1'b1, 32'h2);
		host.start_pulse(5, 12'h0F0);
		wait_idle();
		chk("mode off", power_r, 2'h0);
		chk("pin ignored", n_samp - s0, 3);
		bus(REG_CTRL, 1'b1, 32'h0);
		repeat (WAKE_CYC) @(posedge sys_clk);
		bus(REG_CTRL, 1'b1, 32'h8);
		wait_idle();
		chk("sw start", n_samp - s0, 4);
		bus(REG_CTRL, 1'b0, 32'h0);
		chk("sw bit", rd_v, 32'h0);
		chk("normal on", power_r, 2'h3);
	endtask : t_modes
	// Main sequence
	initial begin
		do_reset();
		t_cancel();
		do_reset();
		t_pon();
		t_modes();
		stop_test();
	end
endmodule : apms_seq_bench

// file: apms_seq_props.sv
/* Port checker for the power-mode sequencer.
 Assumes the host changes the power mode only between conversions. */
`timescale 1ns/10ps
module apms_props #(
	parameter int PON_PHASE_CYC = 50,
	parameter int CONV_CYC = 184
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Bus handshake
	input wire logic [3:0] avs_address,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	// Pin and core side
	input wire logic convert_start_n,
	input wire logic [apms_pkg::SAMPLE_W-1:0] raw_code,
	input wire apms_pkg::apms_power_type power_r,
	input wire logic busy_r,
	input wire logic sample_r,
	input wire logic [apms_pkg::SAMPLE_W-1:0] result_r
);
	import apms_pkg::*;
	logic [1:0] pm_r;
	logic bip_r;
	logic conv_r;
	logic down_r;
	logic [15:0] bcnt_r;
	logic [7:0] fcnt_r;
	wire ctrl_wr = avs_write && !avs_waitrequest && avs_address == REG_CTRL;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// Mode copy, open conversion, busy length, time since pin fall
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pm_r <= 2'h0;
			bip_r <= 1'b0;
			conv_r <= 1'b0;
			down_r <= 1'b0;
			bcnt_r <= 16'h0;
			fcnt_r <= 8'h0;
		end else begin
			if (ctrl_wr) begin
				pm_r <= avs_writedata[1:0];
				bip_r <= avs_writedata[2];
			end
			conv_r <= sample_r | (busy_r & conv_r);
			down_r <= !power_r.core_on | (down_r & !sample_r);
			bcnt_r <= busy_r ? bcnt_r + 16'h1 : 16'h0;
			fcnt_r <= $fell(convert_start_n) ? 8'h0 : fcnt_r + {7'h0, fcnt_r != 8'hFF};
		end
	end
	a_full_off_now: assert property (pm_r == 2'h2 && $past(pm_r, 3) == 2'h2 |-> power_r == 2'h0)
		else $error("power on in full power-down");
	a_normal_stays: assert property ($fell(busy_r) && conv_r && pm_r == 2'h0 |=> power_r == 2'h3)
		else $error("normal mode powered down");
	a_full_after: assert property ($fell(busy_r) && conv_r && pm_r == 2'h1 |-> ##[0:1] power_r == 2'h0)
		else $error("no full power-down after conversion");
	a_part_after: assert property ($fell(busy_r) && conv_r && pm_r == 2'h3 |-> ##[0:1] power_r == 2'h1)
		else $error("partial power-down wrong");
	a_conv_length: assert property ($fell(busy_r) && conv_r |-> bcnt_r >= CONV_CYC - 1 && bcnt_r <= CONV_CYC + 1)
		else $error("conversion length wrong");
	a_no_start_busy: assert property (sample_r |-> !$past(busy_r) ##1 !sample_r)
		else $error("start taken while busy");
	a_result_code: assert property ($fell(busy_r) && conv_r |-> ##[0:1] result_r == (raw_code ^ (bip_r ? MID_CODE : 12'h000)))
		else $error("result code wrong");
	a_wake_first: assert property (sample_r && down_r |-> fcnt_r >= WAKE_CYC)
		else $error("conversion before wake-up");
	a_reset_state: assert property ($fell(srst) |-> power_r == 2'h3 && !busy_r)
		else $error("bad state after reset");
	c_part_cycle: cover property ($fell(busy_r) && conv_r && pm_r == 2'h3);
	c_woken_conv: cover property (sample_r && down_r);
	c_bipolar: cover property ($fell(busy_r) && conv_r && bip_r);
endmodule : apms_props
bind apms_seq apms_props #(.PON_PHASE_CYC(PON_PHASE_CYC), .CONV_CYC(CONV_CYC)) u_props (
	.sys_clk, .srst, .avs_address, .avs_write, .avs_writedata, .avs_waitrequest,
	.convert_start_n, .raw_code, .power_r, .busy_r, .sample_r, .result_r);

// file: apms_sync.sv
/*
 Three-stage synchroniser with agreement filter for an asynchronous pin.
 Assumes the pin is a plain level from outside the sys_clk domain.
*/
`timescale 1ns/10ps
module apms_sync (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Pin in, filtered level out
	input wire logic pin_in,
	output logic level_out
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// First stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			level_out <= 1'b1;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_out <= s3_r; // Change counts once stages agree
			end
		end
	end
endmodule : apms_sync
